/* rtl/bmc_defs.svh */
// constants for the basic mode control bits block
`ifndef BMC_DEFS_SVH
`define BMC_DEFS_SVH
`define BMC_RESTART_BIT 4'h9
`define BMC_DUPLEX_BIT 4'h8
`define BMC_COLTEST_BIT 4'h7
`define BMC_ANEN_BIT 4'hC
`define BMC_RESTART_RST 1'h0
`define BMC_DUPLEX_RST 1'h1
`define BMC_COLTEST_RST 1'h0
`define BMC_RSVD_RST 7'h00
`endif

/* rtl/bmc_pkg.sv */
// types for the basic mode control bits block
package bmc_pkg;
  // written field values, sent alongside the separate WR_EN write strobe
  typedef struct packed {
    logic restart;
    logic duplex;
    logic coltest;
  } bmc_wr_t;
  // whole state of the block
  typedef struct packed {
    logic restart;
    logic duplex;
    logic coltest;
    logic col;
  } bmc_state_t;
endpackage : bmc_pkg

/* rtl/bmc_ctrl.sv */
// basic mode control bits: restart, duplex, collision test, reserved
// Overview of operation
// (R1) restart bit is read/write, resets to zero, self clears, write one restarts
// (R2) management keeps restart cleared while auto-negotiation is disabled
// (R3) restart reads one until negotiation actually starts, then clears itself
// (R4) clearing restart does not disturb negotiation already under way
// (R5) duplex bit read/write, resets to one; one full, zero half duplex
// (R6) written duplex governs operation only while auto-negotiation disabled
// (R7) with auto-negotiation enabled duplex reads the negotiated duplex
// (R8) collision test bit read/write, resets to zero; one enables test
// (R9) test in half duplex with transmit active raises collision
// (R10) seven low bits reserved, reset zero, written zero, read ignored
// (R11) test collision ends when transmit ends or test bit clears
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defs.svh"
module bmc_ctrl
  import bmc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic WR_EN,
  input wire bmc_wr_t WR_DATA,
  input wire logic AN_ENABLE,
  input wire logic AN_STARTED,
  input wire logic AN_DUPLEX,
  input wire logic TX_ACTIVE,
  output logic [15:0] RD_DATA,
  output logic AN_RESTART,
  output logic FULL_DUPLEX,
  output logic COL_TEST
);
  // ****************************************
  // state
  // ****************************************
  bmc_state_t st_ff;
  bmc_state_t nxt_st;
  logic duplex_eff;

  // effective duplex
  // (R6) written duplex only
  // (R7) negotiated when enabled
  assign duplex_eff = AN_ENABLE ? AN_DUPLEX : st_ff.duplex;

  // next state; writes and hardware events
  always_comb begin
    nxt_st = st_ff;
    if (WR_EN) begin
      // (R1) write one restarts
      nxt_st.restart = WR_DATA.restart;
      // (R5) duplex select
      nxt_st.duplex = WR_DATA.duplex;
      // (R8) collision test select
      nxt_st.coltest = WR_DATA.coltest;
    end
    // (R3) self clear on start; start wins over a same-cycle write
    if (AN_STARTED) begin
      nxt_st.restart = 1'h0;
    end
    // (R9) collision in half duplex while transmitting
    // (R11) ends with transmit or test bit
    nxt_st.col = nxt_st.coltest & ~duplex_eff & TX_ACTIVE;
  end

  // registered state
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff.restart <= `BMC_RESTART_RST;
      st_ff.duplex <= `BMC_DUPLEX_RST;
      st_ff.coltest <= `BMC_COLTEST_RST;
      st_ff.col <= 1'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // read back and outputs
  // ****************************************
  // (R10) reserved bits read zero; (R4) clearing restart only drops the request
  always_comb begin
    RD_DATA = 16'h0000;
    RD_DATA[`BMC_RESTART_BIT] = st_ff.restart;
    RD_DATA[`BMC_DUPLEX_BIT] = duplex_eff;
    RD_DATA[`BMC_COLTEST_BIT] = st_ff.coltest;
    RD_DATA[`BMC_ANEN_BIT] = AN_ENABLE;
    RD_DATA[6:0] = `BMC_RSVD_RST;
  end
  // (R2) request gated by enable; restart meaningless when disabled
  assign AN_RESTART = st_ff.restart & AN_ENABLE;
  assign FULL_DUPLEX = duplex_eff;
  assign COL_TEST = st_ff.col;

  // ****************************************
  // checks
  // ****************************************
  // all checks run on the block clock and sleep through reset; the
  // negotiation and transmit inputs come from logic on the same clock,
  // so they need no extra sampling margin here
  // several checks skip write cycles on purpose: a write may legally
  // move the very bit under test in the same cycle
  // the collision checks allow one cycle of lag, since the collision
  // state is registered to keep the output free of glitches

  // (R3) restart holds on
  property p_restart_hold;
    @(posedge MCLK) disable iff (!RST_N)
      st_ff.restart && !AN_STARTED && !WR_EN |=> st_ff.restart;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart dropped early"); // (R3)

  // (R1) self clear on start
  property p_restart_clear;
    @(posedge MCLK) disable iff (!RST_N) AN_STARTED |=> !st_ff.restart;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart not cleared"); // (R1)

  // (R1) write one sets
  property p_restart_set;
    @(posedge MCLK) disable iff (!RST_N)
      WR_EN && WR_DATA.restart && !AN_STARTED |=> st_ff.restart;
  endproperty
  a_restart_set: assert property (p_restart_set) else $error("restart write lost"); // (R1)

  // (R2) request needs enable
  property p_req_gate;
    @(posedge MCLK) disable iff (!RST_N) !AN_ENABLE |-> !AN_RESTART;
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("restart request while disabled"); // (R2)

  // (R4) clearing drops request
  property p_restart_drop;
    @(posedge MCLK) disable iff (!RST_N) WR_EN && !WR_DATA.restart |=> !AN_RESTART;
  endproperty
  a_restart_drop: assert property (p_restart_drop) else $error("restart request kept after clear"); // (R4)

  // (R6) manual duplex governs
  property p_dup_man;
    @(posedge MCLK) disable iff (!RST_N) !AN_ENABLE |-> FULL_DUPLEX == st_ff.duplex;
  endproperty
  a_dup_man: assert property (p_dup_man) else $error("manual duplex ignored"); // (R6)

  // (R7) negotiated duplex shown
  property p_dup_an;
    @(posedge MCLK) disable iff (!RST_N) AN_ENABLE |-> RD_DATA[8] == AN_DUPLEX;
  endproperty
  a_dup_an: assert property (p_dup_an) else $error("negotiated duplex not shown"); // (R7)

  // (R5) duplex write lands
  property p_dup_wr;
    @(posedge MCLK) disable iff (!RST_N) WR_EN |=> st_ff.duplex == $past(WR_DATA.duplex);
  endproperty
  a_dup_wr: assert property (p_dup_wr) else $error("duplex write lost"); // (R5)

  // (R8) test bit write lands
  property p_ct_wr;
    @(posedge MCLK) disable iff (!RST_N) WR_EN |=> RD_DATA[7] == $past(WR_DATA.coltest);
  endproperty
  a_ct_wr: assert property (p_ct_wr) else $error("coltest write lost"); // (R8)

  // (R9) collision in half duplex
  property p_col_on;
    @(posedge MCLK) disable iff (!RST_N)
      st_ff.coltest && !WR_EN && !duplex_eff && TX_ACTIVE |=> COL_TEST;
  endproperty
  a_col_on: assert property (p_col_on) else $error("no test collision"); // (R9)

  // (R9) never in full duplex
  property p_col_full;
    @(posedge MCLK) disable iff (!RST_N) FULL_DUPLEX |=> !COL_TEST;
  endproperty
  a_col_full: assert property (p_col_full) else $error("test collision in full duplex"); // (R9)

  // (R11) ends with transmit
  property p_col_off;
    @(posedge MCLK) disable iff (!RST_N) !TX_ACTIVE |=> !COL_TEST;
  endproperty
  a_col_off: assert property (p_col_off) else $error("collision outlived transmit"); // (R11)

  // (R11) ends with test bit
  property p_ct_clear;
    @(posedge MCLK) disable iff (!RST_N) WR_EN && !WR_DATA.coltest |=> !COL_TEST;
  endproperty
  a_ct_clear: assert property (p_ct_clear) else $error("collision outlived test bit"); // (R11)

  // (R10) reserved reads zero
  property p_rsvd;
    @(posedge MCLK) disable iff (!RST_N) RD_DATA[6:0] == 7'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero"); // (R10)

  // ****************************************
  // coverage of the main scenarios
  // ****************************************
  // restart requested and later picked up by the engine
  c_restart: cover property (@(posedge MCLK) WR_EN && WR_DATA.restart ##[1:20] AN_STARTED);
  // test collision raised and then dropped
  c_col: cover property (@(posedge MCLK) COL_TEST ##1 !COL_TEST);
  // manual half duplex in force
  c_dup: cover property (@(posedge MCLK) !AN_ENABLE && !FULL_DUPLEX);
  // test collision under negotiated half duplex
  c_an_half: cover property (@(posedge MCLK) AN_ENABLE && !AN_DUPLEX && COL_TEST);
  // engine start meets a restart write in one cycle
  c_race: cover property (@(posedge MCLK) WR_EN && WR_DATA.restart && AN_STARTED);
endmodule : bmc_ctrl
`default_nettype wire

/* testbench/bmc_mgmt.sv */
// management entity model issuing one-cycle writes
`timescale 1ns/1ps
`default_nettype none
module bmc_mgmt
  import bmc_pkg::*;
(
  input wire logic MCLK,
  output logic WR_EN,
  output bmc_wr_t WR_DATA
);
  initial begin
    WR_EN = 1'h0;
    WR_DATA = 3'h0;
  end
  // only the three fields are ever written, reserved bits stay zero
  task automatic wr(input bmc_wr_t v);
    @(posedge MCLK) #1;
    WR_EN = 1'h1;
    WR_DATA = v;
    @(posedge MCLK) #1;
    WR_EN = 1'h0;
    WR_DATA = ~v; // stale data must not be mistaken for a write
  endtask : wr
endmodule : bmc_mgmt
`default_nettype wire

/* testbench/bmc_ctrl_bench.sv */
// self-checking bench for the basic mode control bits
`timescale 1ns/1ps
`default_nettype none
module bmc_ctrl_bench;
  import bmc_pkg::*;
  logic MCLK = 1'h0;
  logic RST_N, AN_ENABLE, AN_STARTED, AN_DUPLEX, TX_ACTIVE;
  logic WR_EN, AN_RESTART, FULL_DUPLEX, COL_TEST;
  bmc_wr_t WR_DATA;
  logic [15:0] RD_DATA;
  int n_mismatch = 0, checked = 0, cyc = 0;
  bmc_mgmt u_mgmt (.MCLK(MCLK), .WR_EN(WR_EN), .WR_DATA(WR_DATA));
  bmc_ctrl u_dut (.MCLK(MCLK), .RST_N(RST_N), .WR_EN(WR_EN), .WR_DATA(WR_DATA), .AN_ENABLE(AN_ENABLE),
    .AN_STARTED(AN_STARTED), .AN_DUPLEX(AN_DUPLEX), .TX_ACTIVE(TX_ACTIVE), .RD_DATA(RD_DATA),
    .AN_RESTART(AN_RESTART), .FULL_DUPLEX(FULL_DUPLEX), .COL_TEST(COL_TEST));
  always #4 MCLK = ~MCLK;
  // hang guard: the scenarios need well under 100 cycles
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 500) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic clk(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : clk
  task automatic end_sim();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // **********
  // scenarios
  // **********
  task automatic t_restart();
    AN_ENABLE = 1'h1;
    AN_DUPLEX = 1'h1;
    u_mgmt.wr(3'h4);
    chk("rd", RD_DATA, 16'h1300);
    clk(3);
    chk("req", AN_RESTART, 1'h1);
    AN_STARTED = 1'h1;
    clk(1);
    AN_STARTED = 1'h0;
    chk("rd", RD_DATA, 16'h1100);
    u_mgmt.wr(3'h4);
    u_mgmt.wr(3'h0);
    chk("req", AN_RESTART, 1'h0);
    chk("dup", FULL_DUPLEX, 1'h1);
  endtask : t_restart
  task automatic t_duplex();
    AN_ENABLE = 1'h0;
    clk(1);
    chk("dup", FULL_DUPLEX, 1'h0);
    u_mgmt.wr(3'h2);
    chk("rd", RD_DATA, 16'h0100);
  endtask : t_duplex
  task automatic t_col();
    TX_ACTIVE = 1'h1;
    u_mgmt.wr(3'h3);
    clk(1);
    chk("col", COL_TEST, 1'h0);
    u_mgmt.wr(3'h1);
    clk(1);
    chk("col", COL_TEST, 1'h1);
    TX_ACTIVE = 1'h0;
    clk(1);
    chk("col", COL_TEST, 1'h0);
    TX_ACTIVE = 1'h1;
    u_mgmt.wr(3'h0);
    clk(1);
    chk("col", COL_TEST, 1'h0);
  endtask : t_col
  task automatic t_an_half();
    AN_ENABLE = 1'h1;
    AN_DUPLEX = 1'h0;
    u_mgmt.wr(3'h1);
    chk("col", COL_TEST, 1'h1);
    chk("dup", FULL_DUPLEX, 1'h0);
    AN_DUPLEX = 1'h1;
    clk(1);
    chk("col", COL_TEST, 1'h0);
    chk("rd", RD_DATA, 16'h1180);
    fork
      u_mgmt.wr(3'h4);
      begin
        clk(1);
        AN_STARTED = 1'h1;
        clk(1);
        AN_STARTED = 1'h0;
      end
    join
    chk("rd", RD_DATA, 16'h1100);
    chk("col", COL_TEST, 1'h0);
  endtask : t_an_half
  task automatic t_rerst();
    TX_ACTIVE = 1'h0;
    AN_ENABLE = 1'h0;
    RST_N = 1'h0;
    clk(2);
    chk("rd", RD_DATA, 16'h0100);
    chk("col", COL_TEST, 1'h0);
    RST_N = 1'h1;
    clk(1);
    u_mgmt.wr(3'h0);
    chk("dup", FULL_DUPLEX, 1'h0);
  endtask : t_rerst
  initial begin
    RST_N = 1'h0;
    AN_ENABLE = 1'h0;
    AN_STARTED = 1'h0;
    AN_DUPLEX = 1'h0;
    TX_ACTIVE = 1'h0;
    clk(2);
    RST_N = 1'h1;
    chk("rd", RD_DATA, 16'h0100);
    t_restart();
    t_duplex();
    t_col();
    t_an_half();
    t_rerst();
    end_sim();
  end
endmodule : bmc_ctrl_bench
`default_nettype wire
